// >>> src/swr_pkg.sv
// package: register map, field positions, reset values and timing counts for the stop/wake block
// How it works
// - entering stop halts the crystal and every internal clock.
// - interrupt wake with ring select active runs at once from the ring oscillator.
// - on ring, count a power-on interval of crystal clocks, then switch to crystal.
// - re-entering stop before the switch turns all clocks off again.
// - by default stop exit waits for the crystal, not the ring; here the core runs from the crystal at once on wake.
// - extended flag bit 1 enables ring wake from stop.
// - extended flag bit 2 reads one while the ring clocks the core.
// - key 0xAA then 0x55 opens a three-cycle protected write window.
// - protected bit writes without the preceding key are ignored.
// - protection covers bandgap select, por flag, watchdog enable, restart and irq flag.
// - extended flag bit 0 keeps bandgap on in stop; resets to zero.
// - watchdog restart bit restarts the watchdog for a full interval.
package swr_pkg;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_EXTENDED_FLAG = 8'h91;
  localparam logic [7:0] ADDR_TIMED_ACCESS = 8'hc7;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL = 8'hd8;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'he1;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'he2;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'he3;
  // power control fields
  localparam int PC_IDLE = 0;
  localparam int PC_STOP = 1;
  // extended flag fields
  localparam int EF_BANDGAP = 0;
  localparam int EF_RING_SEL = 1;
  localparam int EF_RING_ACT = 2;
  // watchdog control fields
  localparam int WD_RESTART = 0;
  localparam int WD_ENABLE = 1;
  localparam int WD_IRQ_FLAG = 3;
  localparam int WD_POR_FLAG = 6;
  localparam logic [7:0] WD_PROT_MASK = 8'h4b;
  localparam logic [7:0] EF_PROT_MASK = 8'h01;
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] EF_RESET = 8'h00;
  localparam logic [7:0] WD_RESET = 8'h40;
  // irq status bits
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_SWITCH = 1;
  localparam int IRQ_STOP = 2;
  localparam logic [7:0] IRQ_MASK = 8'h07;
  // timed access keys and window
  localparam logic [7:0] KEY_FIRST = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam logic [1:0] TA_WINDOW_CYCLES = 2'h3;
  // power-on reset interval in crystal clocks
  localparam int POR_CLOCKS = 65536;
  localparam logic [16:0] POR_COUNT = 17'h1_0000;
  typedef enum logic [1:0] {
    SWR_RUN_XTAL = 2'b00,
    SWR_STOPPED = 2'b01,
    SWR_RUN_RING = 2'b10
  } swr_mode_t;
endpackage

// >>> src/swr_ta_if.sv
// interface: timed-access gate request and grant between top and gate
`timescale 1ns/1ns
interface swr_ta_if;
  logic key_wr;
  logic [7:0] key_data;
  logic prot_wr;
  logic open;
  modport gate (input key_wr, input key_data, input prot_wr, output open);
  modport user (output key_wr, output key_data, output prot_wr, input open);
endinterface

// >>> src/swr_ta_gate.sv
// module: timed-access unlock gate with a three-cycle write window
`timescale 1ns/1ns
module swr_ta_gate (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  swr_ta_if.gate ta // key and protected write strobes
);
  typedef struct packed {
    logic armed;
    logic [1:0] left;
  } swr_ta_st_t;
  swr_ta_st_t s_q, s_d;
  assign ta.open = (s_q.left != 2'h0);
  // a key byte other than 0x55 or 0xAA disarms; the window is one-shot
  always_comb begin
    s_d = s_q;
    if (s_q.left != 2'h0) begin
      s_d.left = s_q.left - 2'h1;
    end
    if (ta.prot_wr && ta.open) begin
      s_d.left = 2'h0;
    end
    if (ta.key_wr) begin
      if (s_q.armed && ta.key_data == swr_pkg::KEY_SECOND) begin
        s_d.left = swr_pkg::TA_WINDOW_CYCLES;
        s_d.armed = 1'b0;
      end else begin
        s_d.armed = (ta.key_data == swr_pkg::KEY_FIRST);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // swr_ta_gate

// >>> src/swr_por_timer.sv
// module: power-on reset interval counter for the ring-to-crystal switch
`timescale 1ns/1ns
module swr_por_timer (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic run, // count while high, clear while low
  input wire logic xtal_tick, // one crystal clock counted
  output logic done // one-cycle pulse at interval end
);
  typedef struct packed {
    logic [16:0] cnt;
    logic done;
  } swr_por_st_t;
  swr_por_st_t s_q, s_d;
  assign done = s_q.done;
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!run) begin
      s_d.cnt = 17'h0_0000;
    end else if (xtal_tick && !s_q.done) begin
      if (s_q.cnt == swr_pkg::POR_COUNT - 17'h0_0001) begin
        s_d.done = 1'b1;
        s_d.cnt = 17'h0_0000;
      end else begin
        s_d.cnt = s_q.cnt + 17'h0_0001;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // swr_por_timer

// >>> src/swr_top.sv
// module: stop-mode wake controller with ring clock selection and timed access
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
module swr_top (
  input wire logic clk, // system clock, 25 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic wake_irq, // external interrupt wake request
  input wire logic xtal_tick, // crystal clock counted, after startup
  output logic clocks_on, // internal clocks running
  output logic xtal_osc_on, // crystal oscillator enabled
  output logic ring_osc_on, // ring oscillator enabled
  output logic core_on_ring, // core clocked by ring
  output logic bandgap_on, // bandgap reference powered
  output logic wdog_restart, // watchdog restart pulse
  output logic wdog_enable, // watchdog enable level
  output logic irq // level interrupt
);
  typedef struct packed {
    swr_pkg::swr_mode_t mode;
    logic [7:0] power_control;
    logic [7:0] ext;
    logic [7:0] wdc;
    logic [7:0] ist;
    logic [7:0] ien;
    logic [7:0] rdata;
    logic restart;
  } swr_st_t;
  swr_st_t s_q, s_d;
  logic por_done;
  swr_ta_if ta ();

  // protected bits need the open window, others always write
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv,
                                       input logic [7:0] prot, input logic open);
    logic [7:0] m;
    m = open ? 8'hff : ~prot;
    return (old & ~m) | (nv & m);
  endfunction

  assign ta.key_wr = wr && addr == swr_pkg::ADDR_TIMED_ACCESS;
  assign ta.key_data = wdata;
  // any write to a register holding protected bits consumes the window
  assign ta.prot_wr = wr && (addr == swr_pkg::ADDR_WATCHDOG_CONTROL ||
                             addr == swr_pkg::ADDR_EXTENDED_FLAG);

  swr_ta_gate u_gate (
    .clk(clk),
    .srst(srst),
    .ta(ta)
  );

  swr_por_timer u_por (
    .clk(clk),
    .srst(srst),
    .run(s_q.mode == swr_pkg::SWR_RUN_RING),
    .xtal_tick(xtal_tick),
    .done(por_done)
  );

  // clock outputs follow mode; stop kills crystal and all clocks
  assign clocks_on = (s_q.mode != swr_pkg::SWR_STOPPED);
  assign xtal_osc_on = (s_q.mode == swr_pkg::SWR_RUN_XTAL);
  assign ring_osc_on = (s_q.mode == swr_pkg::SWR_RUN_RING);
  assign core_on_ring = s_q.ext[swr_pkg::EF_RING_ACT];
  assign bandgap_on = (s_q.mode != swr_pkg::SWR_STOPPED) ||
                      s_q.ext[swr_pkg::EF_BANDGAP];
  assign wdog_restart = s_q.restart;
  assign wdog_enable = s_q.wdc[swr_pkg::WD_ENABLE];
  assign irq = |(s_q.ist & s_q.ien);
  assign rdata = s_q.rdata;

  // main state: registers, mode machine, sticky events
  always_comb begin
    s_d = s_q;
    s_d.restart = 1'b0;
    s_d.rdata = 8'h00;
    if (wr) begin
      unique case (addr)
        swr_pkg::ADDR_POWER_CONTROL: begin
          s_d.power_control = wdata;
        end
        swr_pkg::ADDR_EXTENDED_FLAG: begin
          s_d.ext = merge(s_q.ext, wdata & 8'h03, swr_pkg::EF_PROT_MASK, ta.open);
          s_d.ext[swr_pkg::EF_RING_ACT] = s_q.ext[swr_pkg::EF_RING_ACT];
        end
        swr_pkg::ADDR_WATCHDOG_CONTROL: begin
          s_d.wdc = merge(s_q.wdc, wdata, swr_pkg::WD_PROT_MASK, ta.open);
          if (ta.open && wdata[swr_pkg::WD_RESTART]) begin
            s_d.restart = 1'b1;
          end
          s_d.wdc[swr_pkg::WD_RESTART] = 1'b0;
        end
        swr_pkg::ADDR_IRQ_ENABLE: begin
          s_d.ien = wdata & swr_pkg::IRQ_MASK;
        end
        swr_pkg::ADDR_IRQ_CLEAR: begin
          s_d.ist = s_q.ist & ~wdata;
        end
        default: begin
        end
      endcase
    end
    unique case (s_q.mode)
      swr_pkg::SWR_RUN_XTAL: begin
        if (s_q.power_control[swr_pkg::PC_STOP]) begin
          s_d.mode = swr_pkg::SWR_STOPPED;
          s_d.ist[swr_pkg::IRQ_STOP] = 1'b1;
        end
      end
      swr_pkg::SWR_STOPPED: begin
        if (wake_irq) begin
          s_d.power_control[swr_pkg::PC_STOP] = 1'b0;
          s_d.ist[swr_pkg::IRQ_WAKE] = 1'b1;
          if (s_q.ext[swr_pkg::EF_RING_SEL]) begin
            s_d.mode = swr_pkg::SWR_RUN_RING;
            s_d.ext[swr_pkg::EF_RING_ACT] = 1'b1;
          end else begin
            s_d.mode = swr_pkg::SWR_RUN_XTAL;
          end
        end
      end
      swr_pkg::SWR_RUN_RING: begin
        if (s_q.power_control[swr_pkg::PC_STOP]) begin
          s_d.mode = swr_pkg::SWR_STOPPED;
          s_d.ext[swr_pkg::EF_RING_ACT] = 1'b0;
          s_d.ist[swr_pkg::IRQ_STOP] = 1'b1;
        end else if (por_done) begin
          s_d.mode = swr_pkg::SWR_RUN_XTAL;
          s_d.ext[swr_pkg::EF_RING_ACT] = 1'b0;
          s_d.ist[swr_pkg::IRQ_SWITCH] = 1'b1;
        end
      end
      default: begin
        s_d.mode = swr_pkg::SWR_RUN_XTAL;
      end
    endcase
    // reads return state one cycle later
    if (rd) begin
      unique case (addr)
        swr_pkg::ADDR_POWER_CONTROL: s_d.rdata = s_q.power_control;
        swr_pkg::ADDR_EXTENDED_FLAG: s_d.rdata = s_q.ext;
        swr_pkg::ADDR_WATCHDOG_CONTROL: s_d.rdata = s_q.wdc;
        swr_pkg::ADDR_IRQ_STATUS: s_d.rdata = s_q.ist;
        swr_pkg::ADDR_IRQ_ENABLE: s_d.rdata = s_q.ien;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q.mode <= swr_pkg::SWR_RUN_XTAL;
      s_q.power_control <= swr_pkg::PC_RESET;
      s_q.ext <= swr_pkg::EF_RESET;
      s_q.wdc <= swr_pkg::WD_RESET;
      s_q.ist <= 8'h00;
      s_q.ien <= 8'h00;
      s_q.rdata <= 8'h00;
      s_q.restart <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // swr_top

// >>> verification/swr_top_sva.sv
// checker: port-level assertions for the stop/wake controller
`timescale 1ns/1ns
module swr_top_sva (
  input wire logic clk, // system clock
  input wire logic srst, // sync reset
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic wake_irq, // wake request
  input wire logic clocks_on, // clocks running
  input wire logic xtal_osc_on, // crystal on
  input wire logic ring_osc_on, // ring on
  input wire logic core_on_ring, // ring status
  input wire logic bandgap_on, // bandgap powered
  input wire logic wdog_restart // restart pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // key bytes as the bench spaces them: one idle cycle apart
  sequence key_seq;
    wr && addr == 8'hc7 && wdata == 8'haa ##2 wr && addr == 8'hc7 && wdata == 8'h55;
  endsequence
  sequence stop_wr;
    wr && addr == 8'h87 && wdata[1];
  endsequence
  a_stop_halts: assert property (stop_wr |-> ##2 !clocks_on)
    else $error("stop write did not halt clocks");
  a_stop_all_off: assert property (!clocks_on |-> !xtal_osc_on && !ring_osc_on && !core_on_ring)
    else $error("oscillator left running in stop");
  a_wake_runs: assert property (!clocks_on && wake_irq |=> clocks_on)
    else $error("wake did not restart clocks");
  a_ring_from_stop: assert property ($rose(ring_osc_on) |-> !$past(clocks_on))
    else $error("ring started outside a stop exit");
  a_ring_to_xtal: assert property ($fell(ring_osc_on) && clocks_on |-> xtal_osc_on)
    else $error("ring left without crystal taking over");
  a_bandgap_run: assert property (clocks_on |-> bandgap_on)
    else $error("bandgap off while running");
  a_keyed_restart: assert property (key_seq ##2 (wr && addr == 8'hd8 && wdata[0]) |=> wdog_restart)
    else $error("keyed restart gave no pulse");
  // second key byte as a plain net, so that $past sees a signal
  logic key_second;
  assign key_second = wr && addr == 8'hc7 && wdata == 8'h55;
  // a pulse needs a control write that fell inside the three-cycle window
  a_unkeyed_write: assert property (wdog_restart |-> $past(wr) && $past(addr) == 8'hd8 &&
    ($past(key_second, 2) || $past(key_second, 3) || $past(key_second, 4)))
    else $error("restart pulse without a keyed write");
  a_restart_pulse: assert property (wdog_restart |=> !wdog_restart)
    else $error("restart pulse longer than one cycle");
endmodule // swr_top_sva

bind swr_top swr_top_sva u_sva (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
  .wake_irq(wake_irq), .clocks_on(clocks_on), .xtal_osc_on(xtal_osc_on),
  .ring_osc_on(ring_osc_on), .core_on_ring(core_on_ring), .bandgap_on(bandgap_on),
  .wdog_restart(wdog_restart));

// >>> verification/stop_wake_ring_clock_timed_access_tb_top.sv
// testbench: directed scenarios for the stop/wake controller
`timescale 1ns/1ns
module stop_wake_ring_clock_timed_access_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wake_irq = 1'b0;
  logic xtal_tick = 1'b1; // crystal taken as started, one tick a cycle
  logic [7:0] rdata;
  logic clocks_on, xtal_osc_on, ring_osc_on, core_on_ring, bandgap_on;
  logic wdog_restart, wdog_enable, irq;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  swr_top u_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wake_irq(wake_irq), .xtal_tick(xtal_tick), .clocks_on(clocks_on),
    .xtal_osc_on(xtal_osc_on), .ring_osc_on(ring_osc_on), .core_on_ring(core_on_ring),
    .bandgap_on(bandgap_on), .wdog_restart(wdog_restart), .wdog_enable(wdog_enable), .irq(irq));
  always #20 clk = ~clk;
  // cut a hang short; the full run needs about 66k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // a gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask
  task automatic unlock();
    wr_reg(8'hc7, 8'haa);
    wr_reg(8'hc7, 8'h55);
  endtask
  task automatic wake();
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    #1;
  endtask
  task automatic t_protect();
    rd_chk(8'h91, 8'h00);
    rd_chk(8'hd8, 8'h40);
    wr_reg(8'hd8, 8'h0b);
    rd_chk(8'hd8, 8'h40);
    unlock();
    // keyed control write by hand, so the restart pulse is seen while it stands
    addr <= 8'hd8;
    wdata <= 8'h43;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1 chk(wdog_restart, 1'b1);
    @(posedge clk);
    #1 chk(wdog_restart, 1'b0);
    chk(wdog_enable, 1'b1);
    rd_chk(8'hd8, 8'h42);
    wr_reg(8'hd8, 8'h40);
    chk(wdog_enable, 1'b1);
    // last cycle of the window still takes a protected write
    unlock();
    @(posedge clk);
    wr_reg(8'h91, 8'h01);
    rd_chk(8'h91, 8'h01);
    unlock();
    wr_reg(8'h91, 8'h00);
    rd_chk(8'h91, 8'h00);
    unlock();
    repeat (2) @(posedge clk);
    wr_reg(8'h91, 8'h01);
    rd_chk(8'h91, 8'h00);
  endtask
  task automatic t_xtal_wake();
    wr_reg(8'he2, 8'h07);
    unlock();
    wr_reg(8'hd8, 8'h43);
    wr_reg(8'h87, 8'h02);
    #1 chk(clocks_on, 1'b0);
    chk(bandgap_on, 1'b0);
    wake();
    chk(xtal_osc_on, 1'b1);
    chk(ring_osc_on, 1'b0);
    chk(irq, 1'b1);
    rd_chk(8'h87, 8'h00);
    wr_reg(8'he3, 8'h07);
    chk(irq, 1'b0);
  endtask
  // ring wake, early stop, then a full interval until the crystal takes over
  task automatic t_ring();
    unlock();
    wr_reg(8'h91, 8'h07);
    rd_chk(8'h91, 8'h03);
    wr_reg(8'he2, 8'h02);
    wr_reg(8'h87, 8'h02);
    #1 chk(bandgap_on, 1'b1);
    wake();
    chk(ring_osc_on, 1'b1);
    chk(core_on_ring, 1'b1);
    chk(irq, 1'b0);
    rd_chk(8'h91, 8'h07);
    wr_reg(8'h87, 8'h02);
    #1 chk(clocks_on, 1'b0);
    wake();
    // crystal ticks held back 100 cycles: only counted ticks may advance the interval
    // the bench does no serial or timing work while ring status is up
    xtal_tick <= 1'b0;
    n = 0;
    while (ring_osc_on === 1'b1 && n < 70000) begin
      @(posedge clk);
      #1 n++;
      if (n == 100) begin
        xtal_tick <= 1'b1;
      end
    end
    chk(n == swr_pkg::POR_CLOCKS + 101, 1'b1);
    #1 chk(xtal_osc_on, 1'b1);
    chk(irq, 1'b1);
    rd_chk(8'h91, 8'h03);
  endtask
  // mid-run reset pulse of one edge; every output, the watchdog control and the extended flag return to their reset levels
  task automatic t_reset();
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk(clocks_on, 1'b1);
    chk(xtal_osc_on, 1'b1);
    chk(ring_osc_on, 1'b0);
    chk(core_on_ring, 1'b0);
    chk(bandgap_on, 1'b1);
    chk(wdog_restart, 1'b0);
    chk(wdog_enable, 1'b0);
    chk(irq, 1'b0);
    chk(rdata, 8'h00);
    rd_chk(8'hd8, 8'h40);
    rd_chk(8'h91, 8'h00);
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_protect();
    t_xtal_wake();
    t_ring();
    t_reset();
    stop_test();
  end
endmodule // stop_wake_ring_clock_timed_access_tb_top
